// file: hw/qdsl_top.sv
/*
  Serial load logic of a quad converter: 3-wire frame receiver, input and
  output registers per channel, load strobe, clear, chaining and an APB
  register view. All link pins are sampled by pclk, which must run well
  above the serial clock (four or more pclk per serial clock phase).
*/
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module qdsl_top #(
  parameter int unsigned RES_BITS = 12
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               sync_n,
  input  wire logic                               sclk,
  input  wire logic                               din,
  input  wire logic                               load_strobe_n,
  input  wire logic                               clear_all_n,
  input  wire logic                               sleep_n,
  input  wire logic                               chain_mode_enable,
  output logic                                    chain_serial_out,
  output logic      [qdsl_pkg::CHANNELS-1:0][RES_BITS-1:0] dac_code,
  output logic      [qdsl_pkg::CHANNELS-1:0]      dac_gain,
  output logic      [qdsl_pkg::CHANNELS-1:0]      dac_buf,
  output logic                                    dac_awake
);
  localparam int unsigned NCH = qdsl_pkg::CHANNELS;
  localparam int unsigned CHW = RES_BITS + 2;

  initial begin
    if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12) begin
      $error("RES_BITS must be 8, 10 or 12");
    end
  end

  // Pin synchronisers
  logic [5:0] pins_s;
  qdsl_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h36)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sync_n, sclk, din, load_strobe_n, sleep_n, chain_mode_enable}),
    .q       (pins_s)
  );
  logic sync_n_s, sclk_s, din_s, load_n_s, sleep_n_s, chain_s;
  assign {sync_n_s, sclk_s, din_s, load_n_s, sleep_n_s, chain_s} = pins_s;

  // Link receiver state
  logic [15:0]              shreg_ff, nxt_shreg;
  logic [qdsl_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                     sclk_d_ff, sync_d_ff, sdo_ff, nxt_sdo;
  logic                     commit_ff, nxt_commit;
  logic [15:0]              word_ff, nxt_word;
  logic [1:0]               ctrl_ff, nxt_ctrl;
  logic                     sclk_fall, sclk_rise, sync_rise;

  assign sclk_fall = sclk_d_ff & ~sclk_s;
  assign sclk_rise = ~sclk_d_ff & sclk_s;
  assign sync_rise = ~sync_d_ff & sync_n_s;

  always_comb begin
    nxt_shreg  = shreg_ff;
    nxt_cnt    = cnt_ff;
    nxt_sdo    = sdo_ff;
    nxt_commit = 1'b0;
    nxt_word   = word_ff;
    if (sync_n_s) begin
      nxt_cnt = '0;
      // Chained frame ends on frame select rising with at least 16 bits in
      if (sync_rise && chain_s && cnt_ff == 5'(qdsl_pkg::FRAME_BITS)) begin
        nxt_commit = ctrl_ff[qdsl_pkg::CTRL_LINK_EN];
        nxt_word   = shreg_ff;
      end
    end else if (ctrl_ff[qdsl_pkg::CTRL_LINK_EN]) begin
      if (sclk_fall && (chain_s || cnt_ff != 5'(qdsl_pkg::FRAME_BITS))) begin
        nxt_shreg = {shreg_ff[14:0], din_s};
        if (cnt_ff != 5'(qdsl_pkg::FRAME_BITS)) begin
          nxt_cnt = cnt_ff + 5'h1;
        end
        // Standalone frame completes on the sixteenth falling edge
        if (!chain_s && cnt_ff == 5'(qdsl_pkg::FRAME_BITS - 1)) begin
          nxt_commit = 1'b1;
          nxt_word   = {shreg_ff[14:0], din_s};
        end
      end
      if (sclk_rise && chain_s) begin
        nxt_sdo = shreg_ff[15];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_ff  <= '0;
      cnt_ff    <= '0;
      sclk_d_ff <= 1'b1;
      sync_d_ff <= 1'b1;
      sdo_ff    <= 1'b0;
      commit_ff <= 1'b0;
      word_ff   <= '0;
    end else begin
      shreg_ff  <= nxt_shreg;
      cnt_ff    <= nxt_cnt;
      sclk_d_ff <= sclk_s;
      sync_d_ff <= sync_n_s;
      sdo_ff    <= nxt_sdo;
      commit_ff <= nxt_commit;
      word_ff   <= nxt_word;
    end
  end
  // An aborted frame never raises commit, so input registers hold

  // Frame decode
  logic [1:0]          wr_ch;
  logic [CHW-1:0]      wr_val;
  assign wr_ch  = {word_ff[qdsl_pkg::POS_SEL_HI], word_ff[qdsl_pkg::POS_SEL_LO]};
  // Narrow variants take only the top code bits
  assign wr_val = {word_ff[qdsl_pkg::POS_BUF], word_ff[qdsl_pkg::POS_GAIN],
                   word_ff[qdsl_pkg::POS_CODE_MSB -: RES_BITS]};

  // Channel registers {buf, gain, code}
  logic [NCH-1:0][CHW-1:0] in_ff, nxt_in, out_ff, nxt_out;
  logic [NCH-1:0]          pend_ff, nxt_pend;
  logic                    load_req;
  logic                    apb_wr_ctrl;

  assign load_req = ~load_n_s | (apb_wr_ctrl & pwdata[qdsl_pkg::CTRL_SW_LOAD]);

  always_comb begin
    nxt_in   = in_ff;
    nxt_out  = out_ff;
    nxt_pend = pend_ff;
    for (int i = 0; i < NCH; i++) begin
      // A level-low strobe is transparent for pending channels
      if (load_req && pend_ff[i]) begin
        nxt_out[i]  = in_ff[i];
        nxt_pend[i] = 1'b0;
      end
      // New frame wins over a same-cycle transfer of the old value
      if (commit_ff && wr_ch == 2'(i)) begin
        nxt_in[i]   = wr_val;
        nxt_pend[i] = 1'b1;
      end
    end
  end

  // Clear pin acts without the clock; sleep does not touch these
  always_ff @(posedge pclk or negedge presetn or negedge clear_all_n) begin
    if (!presetn || !clear_all_n) begin
      in_ff   <= '0;
      out_ff  <= '0;
      pend_ff <= '0;
    end else begin
      in_ff   <= nxt_in;
      out_ff  <= nxt_out;
      pend_ff <= nxt_pend;
    end
  end

  // Outputs held behind flip-flops
  logic                    awake_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      awake_ff <= 1'b1;
    end else begin
      awake_ff <= sleep_n_s;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      dac_code[i] = out_ff[i][RES_BITS-1:0];
      dac_gain[i] = out_ff[i][RES_BITS];
      dac_buf[i]  = out_ff[i][RES_BITS+1];
    end
  end
  assign dac_awake        = awake_ff;
  assign chain_serial_out = sdo_ff;

  // APB slave, zero wait states
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ready_ff, err_ff, nxt_err;
  logic        setup;
  logic [1:0]  aidx;
  assign setup       = psel & ~penable;
  assign aidx        = paddr[3:2];
  assign apb_wr_ctrl = psel & penable & pwrite & ~err_ff & paddr == qdsl_pkg::OFS_CTRL;

  always_comb begin
    nxt_rdata = '0;
    nxt_err   = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      nxt_err = 1'b1;
    end else if (paddr == qdsl_pkg::OFS_CTRL) begin
      nxt_rdata[qdsl_pkg::CTRL_LINK_EN] = ctrl_ff[qdsl_pkg::CTRL_LINK_EN];
    end else if (paddr == qdsl_pkg::OFS_STATUS) begin
      nxt_err = pwrite;
      nxt_rdata[qdsl_pkg::ST_PEND_LSB +: NCH] = pend_ff;
      nxt_rdata[qdsl_pkg::ST_CNT_LSB +: qdsl_pkg::CNT_W] = cnt_ff;
      nxt_rdata[qdsl_pkg::ST_FRAME_ACT] = ~sync_n_s;
      nxt_rdata[qdsl_pkg::ST_CHAIN]     = chain_s;
      nxt_rdata[qdsl_pkg::ST_AWAKE]     = awake_ff;
    end else if ((paddr & 8'hf0) == qdsl_pkg::OFS_INREG0) begin
      nxt_err = pwrite;
      nxt_rdata[RES_BITS-1:0]      = in_ff[aidx][RES_BITS-1:0];
      nxt_rdata[qdsl_pkg::CH_GAIN] = in_ff[aidx][RES_BITS];
      nxt_rdata[qdsl_pkg::CH_BUF]  = in_ff[aidx][RES_BITS+1];
    end else if ((paddr & 8'hf0) == qdsl_pkg::OFS_OUTREG0) begin
      nxt_err = pwrite;
      nxt_rdata[RES_BITS-1:0]      = out_ff[aidx][RES_BITS-1:0];
      nxt_rdata[qdsl_pkg::CH_GAIN] = out_ff[aidx][RES_BITS];
      nxt_rdata[qdsl_pkg::CH_BUF]  = out_ff[aidx][RES_BITS+1];
    end else begin
      nxt_err = 1'b1;
    end
    nxt_ctrl = ctrl_ff;
    if (apb_wr_ctrl) begin
      nxt_ctrl[qdsl_pkg::CTRL_LINK_EN] = pwdata[qdsl_pkg::CTRL_LINK_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      ctrl_ff  <= qdsl_pkg::CTRL_RESET;
    end else begin
      ready_ff <= setup;
      ctrl_ff  <= nxt_ctrl;
      if (setup) begin
        rdata_ff <= pwrite ? 32'h0 : nxt_rdata;
        err_ff   <= nxt_err;
      end else begin
        err_ff   <= 1'b0;
      end
    end
  end

  assign prdata  = rdata_ff;
  assign pready  = ready_ff;
  assign pslverr = err_ff;
endmodule : qdsl_top

`default_nettype wire

// file: shared/qdsl_pkg.sv
/*
  Constants for the quad converter serial load block: frame layout,
  APB register map, reset values and synchroniser depth.
  Assumes a 32-bit APB with word-aligned registers.
*/
`default_nettype none

package qdsl_pkg;
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned CNT_W         = 5;
  localparam int unsigned CHANNELS      = 4;
  localparam int unsigned CODE_MAX_W    = 12;
  localparam int unsigned SYNC_STAGES   = 2;
  // Frame field positions
  localparam int unsigned POS_SEL_HI    = 15;
  localparam int unsigned POS_SEL_LO    = 14;
  localparam int unsigned POS_GAIN      = 13;
  localparam int unsigned POS_BUF       = 12;
  localparam int unsigned POS_CODE_MSB  = 11;
  // Register offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_INREG0    = 8'h10;
  localparam logic [7:0]  OFS_OUTREG0   = 8'h20;
  // Control register fields and reset value
  localparam int unsigned CTRL_SW_LOAD  = 0;
  localparam int unsigned CTRL_LINK_EN  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h2;
  // Status register fields
  localparam int unsigned ST_PEND_LSB   = 0;
  localparam int unsigned ST_CNT_LSB    = 4;
  localparam int unsigned ST_FRAME_ACT  = 12;
  localparam int unsigned ST_CHAIN      = 13;
  localparam int unsigned ST_AWAKE      = 14;
  // Channel register fields (code in low bits)
  localparam int unsigned CH_GAIN       = 16;
  localparam int unsigned CH_BUF        = 17;
endpackage : qdsl_pkg

`default_nettype wire

// file: hw/qdsl_sync.sv
/*
  Two-flop synchroniser for a vector of independent level inputs.
  Assumes each bit is a slow level or an edge seen over many clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module qdsl_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RESET_VAL;
      q_ff    <= RESET_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : qdsl_sync

`default_nettype wire

// file: sim/qdsl_sva.sv
/*
  Checker for the serial load block outputs.
  Assumes it is bound to qdsl_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsl_sva #(
  parameter int unsigned RES_BITS = 12
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     sync_n,
  input wire logic                     sclk,
  input wire logic                     load_strobe_n,
  input wire logic                     clear_all_n,
  input wire logic                     sleep_n,
  input wire logic                     chain_serial_out,
  input wire logic [3:0][RES_BITS-1:0] dac_code,
  input wire logic [3:0]               dac_gain,
  input wire logic [3:0]               dac_buf,
  input wire logic                     dac_awake
);
  logic [3:0] ld_age_ff, nxt_ld_age, rise_age_ff, nxt_rise_age;
  logic [4:0] falls_ff, nxt_falls;
  logic       sclk_ff;
  // Saturating ages, since pins reach outputs through synchronisers
  always_comb begin
    nxt_ld_age = load_strobe_n ? ld_age_ff + 4'(ld_age_ff != 4'hf) : 4'h0;
    nxt_rise_age = (sclk && !sclk_ff) ? 4'h0 : rise_age_ff + 4'(rise_age_ff != 4'hf);
    nxt_falls = sync_n ? 5'h00 : falls_ff + 5'(sclk_ff && !sclk && falls_ff != 5'h1f);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_age_ff   <= 4'hf;
      rise_age_ff <= 4'hf;
      falls_ff    <= 5'h00;
      sclk_ff     <= 1'b1;
    end else begin
      ld_age_ff   <= nxt_ld_age;
      rise_age_ff <= nxt_rise_age;
      falls_ff    <= nxt_falls;
      sclk_ff     <= sclk;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_abort;
    $rose(sync_n) && falls_ff != 5'h00 && falls_ff < 5'h10;
  endsequence
  sequence s_quiet;
    (!clear_all_n || $stable(dac_code))[*8];
  endsequence
  a_clear_zeroes_all: assert property (!clear_all_n |-> dac_code == '0 && dac_gain == '0)
    else $error("clear left a channel nonzero");
  a_reset_state: assert property (!$past(presetn) |-> dac_code == '0 && dac_buf == '0 && dac_awake)
    else $error("power-on state wrong");
  a_code_needs_load: assert property (clear_all_n && $past(clear_all_n) && $changed(dac_code) |-> ld_age_ff < 4'h8)
    else $error("code changed without load strobe");
  a_mode_with_load: assert property ($changed({dac_gain, dac_buf}) && clear_all_n |-> ld_age_ff <= 4'h7 || !$past(clear_all_n))
    else $error("gain or buffer changed without load");
  a_sleep_drops: assert property (!sleep_n [*4] |-> !dac_awake)
    else $error("awake flag ignores sleep");
  a_sleep_wakes: assert property (sleep_n [*4] |-> dac_awake)
    else $error("awake flag stuck low");
  a_chain_on_rise: assert property ($changed(chain_serial_out) |-> rise_age_ff < 4'h8)
    else $error("chain output moved away from a clock rise");
  a_abort_keeps: assert property (s_abort |=> s_quiet)
    else $error("aborted frame changed an output");
endmodule : qdsl_sva
bind qdsl_top qdsl_sva #(.RES_BITS(RES_BITS)) u_sva (.pclk, .presetn, .sync_n, .sclk,
  .load_strobe_n, .clear_all_n, .sleep_n, .chain_serial_out, .dac_code, .dac_gain,
  .dac_buf, .dac_awake);
`default_nettype wire

// file: sim/qdsl_host.sv
/*
  Serial host model: frame select, clock idle high, data MSB first.
  Assumes the caller waits for each frame to finish.
*/
`timescale 1ns/1ps
`default_nettype none
module qdsl_host (
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    din    = 1'b0;
  end
  // Bits past 16 carry the inverted word, so a chained tail is known
  task automatic send(input logic [15:0] w, input int n, input int h);
    #1.3 sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      din = (i < 16) ? w[15 - i] : ~w[31 - i];
      #h sclk = 1'b0;
      #h sclk = 1'b1;
    end
    #h sync_n = 1'b1;
    din = ~din;
    #100;
  endtask : send
endmodule : qdsl_host
`default_nettype wire

// file: sim/quad_dac_serial_load_tb.sv
/*
  Self-checking bench for qdsl_top: frames, load, abort, sleep, chain, clear.
  Assumes qdsl_host as link master and the APB view of the input registers.
*/
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_tb;
  logic            pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic            load_strobe_n = 1'b1, clear_all_n = 1'b1, sleep_n = 1'b1;
  logic            chain_mode_enable = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic            pready, pslverr, sync_n, sclk, din, chain_serial_out, dac_awake, er;
  logic [3:0][11:0] dac_code;
  logic [3:0]      dac_gain, dac_buf, pend = 4'h0;
  logic [13:0]     ein [4] = '{default: 14'h0}, eout [4] = '{default: 14'h0};
  logic [15:0]     w;
  int              n_errors = 0, n_compared = 0;
  qdsl_top #(.RES_BITS(12)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sync_n, .sclk, .din, .load_strobe_n,
    .clear_all_n, .sleep_n, .chain_mode_enable, .chain_serial_out, .dac_code,
    .dac_gain, .dac_buf, .dac_awake);
  qdsl_host host (.sync_n, .sclk, .din);
  always #2.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic apb(input logic [7:0] a, output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      n_errors++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk_all;
    for (int c = 0; c < 4; c++) begin
      chk({18'h0, dac_gain[c], dac_buf[c], dac_code[c]}, {18'h0, eout[c]});
      apb(8'h10 + 8'(4 * c), rd, er);
      chk(rd, {14'h0, ein[c][12], ein[c][13], 4'h0, ein[c][11:0]});
    end
  endtask : chk_all
  task automatic upd;
    for (int c = 0; c < 4; c++) if (pend[c]) eout[c] = ein[c];
    pend = 4'h0;
  endtask : upd
  // Fixed wait: commit lands a few pclk after the sixteenth clock fall, or after frame select rises when chained
  task automatic xfer(input logic [15:0] v, input int n);
    logic [15:0] f;
    f = (n > 16 && chain_mode_enable) ? ~v : v;
    host.send(v, n, 40);
    repeat (12) @(posedge pclk);
    if (n >= 16) begin
      ein[f[15:14]] = f[13:0];
      pend[f[15:14]] = 1'b1;
    end
    if (!load_strobe_n) upd();
    chk_all();
  endtask : xfer
  initial begin
    void'($urandom(32'h68050f70));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, dac_awake}, 32'h1);
    chk_all();
    apb(8'h40, rd, er);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      w = (i < 4) ? {2'(i), 2'(i), (i % 2) ? 12'hfff : 12'h000} : 16'($urandom);
      xfer(w, 16);
    end
    load_strobe_n <= 1'b0;
    repeat (6) @(posedge pclk);
    load_strobe_n <= 1'b1;
    upd();
    repeat (6) @(posedge pclk);
    chk_all();
    xfer(16'($urandom), 9);
    load_strobe_n <= 1'b0;
    xfer(16'($urandom), 20);
    sleep_n <= 1'b0;
    xfer(16'($urandom), 16);
    chk({31'h0, dac_awake}, 32'h0);
    sleep_n <= 1'b1;
    chain_mode_enable <= 1'b1;
    repeat (4) @(posedge pclk);
    w = 16'($urandom);
    xfer(w, 32);
    chk({31'h0, chain_serial_out}, {31'h0, ~w[15]});
    chain_mode_enable <= 1'b0;
    clear_all_n <= 1'b0;
    @(posedge pclk);
    ein = '{default: 14'h0};
    eout = '{default: 14'h0};
    chk_all();
    clear_all_n <= 1'b1;
    final_report();
  end
endmodule : quad_dac_serial_load_tb
`default_nettype wire
